// *** include/bfp_defines.vh ***
`ifndef BFP_DEFINES_VH
`define BFP_DEFINES_VH

// Clock and programming time
`define BFP_CLK_MHZ         25
`define BFP_PROG_TIME_US    4500
`define BFP_PROG_CYCLES     (`BFP_PROG_TIME_US * `BFP_CLK_MHZ)

// Flash geometry, word addresses
`define BFP_BOOT_START      16'hF000
`define BFP_STALL_START     16'hF000
`define BFP_APP_RESET       16'h0000
`define BFP_WORD_BITS       7

// Self-programming operation codes
`define BFP_OP_ERASE        2'h0
`define BFP_OP_WRITE        2'h1
`define BFP_OP_LOCKSET      2'h2

// Lock field positions
`define BFP_LK_GEN_LO       0
`define BFP_LK_GEN_HI       1
`define BFP_LK_APP_LO       2
`define BFP_LK_APP_HI       3
`define BFP_LK_BOOT_LO      4
`define BFP_LK_BOOT_HI      5
`define BFP_LOCK_RESET      6'h3F

// Register offsets
`define BFP_REG_CTRL        2'h0
`define BFP_REG_LOCK        2'h1
`define BFP_REG_VECTOR      2'h2
`define BFP_REG_PAGE        2'h3

// Control register bits
`define BFP_CTRL_BUSY       0
`define BFP_CTRL_RUN        1
`define BFP_CTRL_HALT       2
`define BFP_CTRL_REJECT     3

`endif

// *** rtl/bfp_top.v ***
// Behaviour
// - Concurrent-region program: stalling region stays readable, concurrent region not.
// - Stalling-region program halts the processor until the operation ends.
// - Busy bit stays one while concurrent region blocked; software clears it.
// - Two independent two-bit lock fields for application and boot sections.
// - Lock bits only get programmed; only chip erase or reset returns them to one.
// - General lock levels never restrict store or load instructions.
// - Lock bit one is unprogrammed; both ones leaves a section unrestricted.
// - Application low lock bit programmed rejects writes and erases there.
// - Application high lock bit blocks loads from boot into application.
// - Same codes with vectors in boot mute interrupts while running application.
// - Boot low lock bit programmed rejects writes and erases to boot.
// - Boot high lock bit blocks loads from application into boot.
// - Same codes with vectors in application mute interrupts while running boot.
// - Reset vector is word zero when fuse is one, else boot start.
// - Fuses come only from pins; the processor cannot change them.
// - Address from pointer and extended page; low bits word, high bits page.
// - Target address is latched when an operation starts.
// - Lock setting ignores the pointer and extended page completely.
// - Loads address bytes, pointer bit zero selects the byte.
`timescale 1ns/1ns
`include "bfp_defines.vh"

module bfp_top #(
  parameter integer PROG_CYCLES = `BFP_PROG_CYCLES
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire        boot_reset_fuse,
  input  wire        ivec_in_boot,
  input  wire [15:0] exec_pc,
  input  wire        spm_req,
  input  wire [1:0]  spm_op,
  input  wire [15:0] z_ptr,
  input  wire [7:0]  ext_page_in,
  input  wire [7:0]  spm_data,
  input  wire        ld_req,
  input  wire        chip_erase,
  input  wire        ext_lock_we,
  input  wire [5:0]  ext_lock_data,
  input  wire [1:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  output reg         spm_done,
  output reg         spm_reject,
  output reg         flash_erase,
  output reg         flash_write,
  output reg  [8:0]  page_index_field,
  output reg  [6:0]  word_in_page_field,
  output reg         cpu_halt,
  output reg         rww_read_block,
  output reg         irq_block,
  output reg  [15:0] reset_vector,
  output reg         ld_done,
  output reg         ld_deny,
  output reg  [16:0] ld_byte_addr,
  output reg         ld_byte_sel
);

  localparam [1:0]  ST_IDLE = 2'h0;
  localparam [1:0]  ST_RUN  = 2'h1;
  localparam integer PROG_M1   = PROG_CYCLES - 1;
  localparam [19:0]  PROG_LOAD = PROG_M1[19:0];

  function in_boot;
    input [15:0] word_addr;
    begin
      in_boot = (word_addr >= `BFP_BOOT_START);
    end
  endfunction

  function in_stall;
    input [15:0] word_addr;
    begin
      in_stall = (word_addr >= `BFP_STALL_START);
    end
  endfunction

  reg         rst_meta;
  reg         rst_sync;
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [19:0] cnt_reg;
  reg  [19:0] cnt_next;
  reg  [5:0]  lock_reg;
  wire [5:0]  lock_next;
  reg         busy_reg;
  reg         busy_next;
  reg         halt_next;
  reg         reject_reg;
  reg         reject_next;
  reg         fuse_seen_reg;
  reg         ls_go;
  reg         start_go;
  reg         deny_now;
  reg         ld_deny_now;
  wire [15:0] tgt_word;
  wire [15:0] ld_word;
  wire        exec_boot;
  wire        tgt_boot;
  wire        ld_boot;
  wire        busy_clr;

  // Reset is released through two flops; only rst_sync is used below
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Word address: extended page bit on top, pointer bit zero dropped
  assign tgt_word  = {ext_page_in[0], z_ptr[15:1]};
  assign ld_word   = {ext_page_in[0], z_ptr[15:1]};
  assign exec_boot = in_boot(exec_pc);
  assign tgt_boot  = in_boot(tgt_word);
  assign ld_boot   = in_boot(ld_word);
  assign busy_clr  = reg_wr && (reg_addr == `BFP_REG_CTRL) && reg_wdata[`BFP_CTRL_BUSY];

  // Request decode; stores from the application section never start programming.
  // The general lock bits are deliberately absent from every check here.
  always @* begin
    ls_go    = 1'b0;
    start_go = 1'b0;
    deny_now = 1'b0;
    if (spm_req && (state_reg == ST_IDLE) && rst_sync) begin
      if (spm_op == `BFP_OP_LOCKSET) begin
        ls_go = exec_boot;
        deny_now = !exec_boot;
      end else if (!exec_boot) begin
        deny_now = 1'b1;
      end else if (tgt_boot && !lock_reg[`BFP_LK_BOOT_LO]) begin
        deny_now = 1'b1;
      end else if (!tgt_boot && !lock_reg[`BFP_LK_APP_LO]) begin
        deny_now = 1'b1;
      end else begin
        start_go = 1'b1;
      end
    end
  end

  // Lock bits can only go from one to zero; chip erase or reset restores ones
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_lock
      assign lock_next[gi] = chip_erase ? 1'b1 :
        (lock_reg[gi] & ~(ext_lock_we & ~ext_lock_data[gi])
                      & ~(ls_go & ~spm_data[gi]));
    end
  endgenerate

  always @* begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    busy_next   = busy_reg;
    halt_next   = cpu_halt;
    reject_next = reject_reg;
    // Clear only acts once the operation is over; a start wins over a clear
    if (busy_clr && (state_reg == ST_IDLE)) begin
      busy_next = 1'b0;
    end
    if (deny_now) begin
      reject_next = 1'b1;
    end else if (start_go || ls_go) begin
      reject_next = 1'b0;
    end
    case (state_reg)
      ST_IDLE: begin
        if (start_go) begin
          state_next = ST_RUN;
          cnt_next   = PROG_LOAD;
          if (in_stall(tgt_word)) begin
            halt_next = 1'b1;
          end else begin
            busy_next = 1'b1;
          end
        end
      end
      ST_RUN: begin
        if (cnt_reg == 20'h0_0000) begin
          state_next = ST_IDLE;
          halt_next  = 1'b0;
        end else begin
          cnt_next = cnt_reg - 20'h0_0001;
        end
      end
      default: begin
        state_next = ST_IDLE;
        halt_next  = 1'b0;
      end
    endcase
  end

  always @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      state_reg          <= ST_IDLE;
      cnt_reg            <= 20'h0_0000;
      busy_reg           <= 1'b0;
      cpu_halt           <= 1'b0;
      reject_reg         <= 1'b0;
      lock_reg           <= `BFP_LOCK_RESET;
      spm_done           <= 1'b0;
      spm_reject         <= 1'b0;
      flash_erase        <= 1'b0;
      flash_write        <= 1'b0;
      page_index_field   <= 9'h000;
      word_in_page_field <= 7'h00;
      rww_read_block     <= 1'b0;
    end else begin
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
      busy_reg       <= busy_next;
      cpu_halt       <= halt_next;
      reject_reg     <= reject_next;
      lock_reg       <= lock_next;
      rww_read_block <= busy_next;
      spm_reject     <= deny_now;
      spm_done       <= deny_now || ls_go ||
                        ((state_reg == ST_RUN) && (cnt_reg == 20'h0_0000));
      flash_erase    <= start_go && (spm_op == `BFP_OP_ERASE);
      flash_write    <= start_go && (spm_op == `BFP_OP_WRITE);
      if (start_go) begin
        // Held for the whole operation; later pointer changes do not reach here
        page_index_field   <= tgt_word[15:`BFP_WORD_BITS];
        word_in_page_field <= tgt_word[`BFP_WORD_BITS-1:0];
      end
    end
  end

  // Loads: cross-section reads follow the high lock bits; the concurrent
  // region is unreadable while it is busy
  always @* begin
    ld_deny_now = 1'b0;
    if (exec_boot && !ld_boot && !lock_reg[`BFP_LK_APP_HI]) begin
      ld_deny_now = 1'b1;
    end
    if (!exec_boot && ld_boot && !lock_reg[`BFP_LK_BOOT_HI]) begin
      ld_deny_now = 1'b1;
    end
    if (busy_reg && !in_stall(ld_word)) begin
      ld_deny_now = 1'b1;
    end
  end

  always @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      ld_done      <= 1'b0;
      ld_deny      <= 1'b0;
      ld_byte_addr <= 17'h0_0000;
      ld_byte_sel  <= 1'b0;
      irq_block    <= 1'b0;
    end else begin
      ld_done <= ld_req && !cpu_halt;
      ld_deny <= ld_req && !cpu_halt && ld_deny_now;
      if (ld_req) begin
        ld_byte_addr <= {ext_page_in[0], z_ptr};
        ld_byte_sel  <= z_ptr[0];
      end
      irq_block <= (!lock_reg[`BFP_LK_APP_HI] && ivec_in_boot && !exec_boot) ||
                   (!lock_reg[`BFP_LK_BOOT_HI] && !ivec_in_boot && exec_boot);
    end
  end

  // The fuse is a pin only; it is sampled once after reset release
  always @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      fuse_seen_reg <= 1'b0;
      reset_vector  <= `BFP_APP_RESET;
    end else if (!fuse_seen_reg) begin
      fuse_seen_reg <= 1'b1;
      reset_vector  <= boot_reset_fuse ? `BFP_APP_RESET : `BFP_BOOT_START;
    end
  end

  // Register read port: data one cycle after the strobe, zero elsewhere
  always @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `BFP_REG_CTRL: begin
          reg_rdata <= {12'h000, reject_reg, cpu_halt, (state_reg == ST_RUN), busy_reg};
        end
        `BFP_REG_LOCK: begin
          reg_rdata <= {10'h000, lock_reg};
        end
        `BFP_REG_VECTOR: begin
          reg_rdata <= reset_vector;
        end
        `BFP_REG_PAGE: begin
          reg_rdata <= {page_index_field, word_in_page_field};
        end
        default: begin
          reg_rdata <= 16'h0000;
        end
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule

// *** dv/bfp_checker_sva.sv ***
`timescale 1ns/1ns
module bfp_checker #(
  parameter integer PROG_CYCLES = 8
) (
  input wire        clk,
  input wire        rstn,
  input wire        boot_reset_fuse,
  input wire        spm_req,
  input wire        ld_req,
  input wire        reg_wr,
  input wire        spm_done,
  input wire        spm_reject,
  input wire        flash_erase,
  input wire        flash_write,
  input wire        cpu_halt,
  input wire        rww_read_block,
  input wire        ld_done,
  input wire        ld_deny,
  input wire        ld_byte_sel,
  input wire [1:0]  spm_op,
  input wire [1:0]  reg_addr,
  input wire [15:0] z_ptr,
  input wire [7:0]  ext_page_in,
  input wire [15:0] reg_wdata,
  input wire [15:0] reset_vector,
  input wire [16:0] ld_byte_addr
);
  // Wide enough for the full programming time, not only the short sim value
  reg [19:0] halt_cnt_reg;
  reg [1:0]  rel_cnt_reg;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      halt_cnt_reg <= 20'h0_0000;
      rel_cnt_reg <= 2'h0;
    end else begin
      halt_cnt_reg <= cpu_halt ? halt_cnt_reg + 20'h0_0001 : 20'h0_0000;
      if (rel_cnt_reg != 2'h3)
        rel_cnt_reg <= rel_cnt_reg + 2'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_op_end;
    $fell(cpu_halt) ##0 spm_done;
  endsequence
  sequence s_ld_ans;
    ld_done ##0 (ld_byte_addr[15:0] == $past(z_ptr)) ##0 (ld_byte_sel == ld_byte_addr[0]);
  endsequence
  property p_halt_len; s_op_end |-> halt_cnt_reg == PROG_CYCLES; endproperty
  property p_reject; spm_reject |-> spm_done && !flash_erase && !flash_write && !cpu_halt;
  endproperty
  property p_flash; flash_erase || flash_write |->
    $past(spm_req) && $past(spm_op) == {1'b0, flash_write} && !spm_reject; endproperty
  property p_ld_ans; ld_req && !cpu_halt |=> s_ld_ans; endproperty
  property p_deny; ld_deny |-> ld_done; endproperty
  property p_busy_hold;
    rww_read_block && !(reg_wr && reg_addr == 2'h0 && reg_wdata[0]) |=> rww_read_block;
  endproperty
  property p_rww_start; $rose(rww_read_block) |-> (flash_erase || flash_write) && !cpu_halt;
  endproperty
  property p_reset_vec;
    rel_cnt_reg == 2'h3 |-> reset_vector == (boot_reset_fuse ? 16'h0000 : 16'hF000);
  endproperty
  property p_rww_deny;
    ld_req && !cpu_halt && rww_read_block && !(ext_page_in[0] && (&z_ptr[15:13])) |=> ld_deny;
  endproperty
  property p_halt_ld; cpu_halt |=> !ld_done; endproperty
  a_rww_deny: assert property (p_rww_deny) else $error("busy region load served");
  a_halt_ld: assert property (p_halt_ld) else $error("load served during halt");
  a_halt_len: assert property (p_halt_len) else $error("halt length wrong");
  a_reject: assert property (p_reject) else $error("rejected store had effect");
  a_flash: assert property (p_flash) else $error("flash pulse without store");
  a_ld_ans: assert property (p_ld_ans) else $error("load answer wrong");
  a_deny: assert property (p_deny) else $error("deny without done");
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped");
  a_rww_start: assert property (p_rww_start) else $error("busy rose wrongly");
  a_reset_vec: assert property (p_reset_vec) else $error("reset vector wrong");
endmodule
bind bfp_top bfp_checker #(.PROG_CYCLES(PROG_CYCLES)) chk_u (.clk(clk), .rstn(rstn),
  .boot_reset_fuse(boot_reset_fuse), .spm_req(spm_req), .ld_req(ld_req), .reg_wr(reg_wr),
  .spm_done(spm_done), .spm_reject(spm_reject), .flash_erase(flash_erase),
  .flash_write(flash_write), .cpu_halt(cpu_halt), .rww_read_block(rww_read_block),
  .ld_done(ld_done), .ld_deny(ld_deny), .ld_byte_sel(ld_byte_sel), .spm_op(spm_op),
  .reg_addr(reg_addr), .z_ptr(z_ptr), .reg_wdata(reg_wdata), .reset_vector(reset_vector),
  .ext_page_in(ext_page_in), .ld_byte_addr(ld_byte_addr));

// *** dv/bfp_core_model.sv ***
`timescale 1ns/1ns
module bfp_core_model (
  input  wire        clk,
  output reg  [15:0] exec_pc,
  output reg         spm_req,
  output reg  [1:0]  spm_op,
  output reg  [15:0] z_ptr,
  output reg  [7:0]  ext_page_in,
  output reg  [7:0]  spm_data,
  output reg         ld_req
);
  initial begin
    exec_pc = 16'hF000;
    {spm_req, ld_req, spm_op, z_ptr, ext_page_in, spm_data} = 36'h0_0000_0000;
  end
  // Pointer is scrambled after each request, so only a latched address survives
  task store(input [15:0] pc, input [1:0] op, input [15:0] w, input [7:0] d);
    begin
      @(posedge clk);
      exec_pc <= pc;
      spm_op <= op;
      z_ptr <= {w[14:0], 1'b0};
      ext_page_in <= {7'h00, w[15]};
      spm_data <= d;
      spm_req <= 1'b1;
      @(posedge clk);
      spm_req <= 1'b0;
      z_ptr <= ~z_ptr;
      ext_page_in <= ~ext_page_in;
      spm_data <= ~spm_data;
    end
  endtask
  task load(input [15:0] pc, input [16:0] a);
    begin
      @(posedge clk);
      exec_pc <= pc;
      z_ptr <= a[15:0];
      ext_page_in <= {7'h00, a[16]};
      ld_req <= 1'b1;
      @(posedge clk);
      ld_req <= 1'b0;
      z_ptr <= ~z_ptr;
      ext_page_in <= ~ext_page_in;
    end
  endtask
endmodule

// *** dv/test_boot_flash_protection.sv ***
`timescale 1ns/1ns
module test_boot_flash_protection;
  localparam integer PROG = 8;
  reg         clk, rstn, boot_reset_fuse, ivec_in_boot, chip_erase, ext_lock_we, reg_wr, reg_rd;
  reg  [5:0]  ext_lock_data;
  reg  [1:0]  reg_addr;
  reg  [15:0] reg_wdata;
  wire [15:0] exec_pc, z_ptr, reg_rdata, reset_vector;
  wire [7:0]  ext_page_in, spm_data;
  wire [1:0]  spm_op;
  wire        spm_req, ld_req, spm_done, spm_reject, flash_erase, flash_write, cpu_halt;
  wire        rww_read_block, irq_block, ld_done, ld_deny, ld_byte_sel;
  wire [8:0]  page_index_field;
  wire [6:0]  word_in_page_field;
  wire [16:0] ld_byte_addr;
  integer     num_errors, comparisons, n;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  bfp_core_model core_u (.clk(clk), .exec_pc(exec_pc), .spm_req(spm_req), .spm_op(spm_op),
    .z_ptr(z_ptr), .ext_page_in(ext_page_in), .spm_data(spm_data), .ld_req(ld_req));
  bfp_top #(.PROG_CYCLES(PROG)) dut_u (.clk(clk), .rstn(rstn), .boot_reset_fuse(boot_reset_fuse),
    .ivec_in_boot(ivec_in_boot), .exec_pc(exec_pc), .spm_req(spm_req), .spm_op(spm_op),
    .z_ptr(z_ptr), .ext_page_in(ext_page_in), .spm_data(spm_data), .ld_req(ld_req),
    .chip_erase(chip_erase), .ext_lock_we(ext_lock_we), .ext_lock_data(ext_lock_data),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .spm_done(spm_done), .spm_reject(spm_reject),
    .flash_erase(flash_erase), .flash_write(flash_write), .page_index_field(page_index_field),
    .word_in_page_field(word_in_page_field), .cpu_halt(cpu_halt),
    .rww_read_block(rww_read_block), .irq_block(irq_block), .reset_vector(reset_vector),
    .ld_done(ld_done), .ld_deny(ld_deny), .ld_byte_addr(ld_byte_addr), .ld_byte_sel(ld_byte_sel));
  task summarize;
    begin
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [17:0] seen, input [17:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task rst_seq(input f);
    begin
      rstn <= 1'b0;
      boot_reset_fuse <= f;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
    end
  endtask
  task wr(input [1:0] a, input [15:0] d);
    begin
      @(posedge clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
    end
  endtask
  task rd(input [1:0] a, input [15:0] e);
    begin
      @(posedge clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
    end
  endtask
  task sp(input [15:0] pc, input [1:0] op, input [15:0] w, input [7:0] d);
    begin
      core_u.store(pc, op, w, d);
      #1;
    end
  endtask
  task ldc(input [15:0] pc, input [16:0] a, input deny);
    begin
      core_u.load(pc, a);
      #1;
      chk({ld_done, ld_deny}, {1'b1, deny});
      chk({ld_byte_sel, ld_byte_addr}, {a[0], a});
    end
  endtask
  task wait_done;
    begin
      n = 0;
      while (spm_done !== 1'b1 && n < 40) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      chk(spm_done, 1'b1);
    end
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    num_errors = num_errors + 1;
    summarize;
  end
  initial begin
    {num_errors, comparisons} = 0;
    {rstn, boot_reset_fuse, chip_erase, ext_lock_we, reg_wr, reg_rd} = 6'h00;
    {ivec_in_boot, ext_lock_data} = 7'h7F;
    {reg_addr, reg_wdata} = 18'h0_0000;
    rst_seq(1'b0);
    chk(reset_vector, 16'hF000);
    rd(2'h2, 16'hF000);
    rd(2'h1, 16'h003F);
    sp(16'hF000, 2'h0, 16'h0080, 8'hFF);
    chk({flash_erase, cpu_halt, rww_read_block}, 3'b101);
    chk({page_index_field, word_in_page_field}, 16'h0080);
    wait_done;
    ldc(16'hF000, 17'h00101, 1'b1);
    ldc(16'hF000, 17'h1E001, 1'b0);
    chk(rww_read_block, 1'b1);
    wr(2'h0, 16'h0001);
    chk(rww_read_block, 1'b0);
    sp(16'hF000, 2'h1, 16'h0080, 8'hFF);
    chk(flash_write, 1'b1);
    wait_done;
    wr(2'h0, 16'h0001);
    sp(16'hF000, 2'h0, 16'hF080, 8'hFF);
    chk({cpu_halt, rww_read_block}, 2'b10);
    chk({page_index_field, word_in_page_field}, 16'hF080);
    // A load while halted gets no answer and uses two of the halt cycles
    core_u.load(16'hF000, 17'h1_E000);
    #1;
    chk(ld_done, 1'b0);
    wait_done;
    chk(n[16:0], PROG - 2);
    sp(16'h0100, 2'h0, 16'h0080, 8'hFF);
    chk({spm_reject, flash_erase}, 2'b10);
    sp(16'hF000, 2'h2, 16'h1234, 8'hF8);
    chk({spm_done, spm_reject}, 2'b10);
    rd(2'h1, 16'h0038);
    sp(16'hF000, 2'h0, 16'h0080, 8'hFF);
    chk(spm_reject, 1'b1);
    ldc(16'hF000, 17'h00100, 1'b0);
    sp(16'hF000, 2'h2, 16'h0001, 8'hC7);
    rd(2'h1, 16'h0000);
    sp(16'hF000, 2'h0, 16'hF080, 8'hFF);
    chk(spm_reject, 1'b1);
    ldc(16'hF000, 17'h00100, 1'b1);
    ldc(16'h0100, 17'h1E000, 1'b1);
    @(posedge clk);
    #1;
    chk(irq_block, 1'b1);
    ldc(16'hF000, 17'h1E000, 1'b0);
    ivec_in_boot <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(irq_block, 1'b1);
    ivec_in_boot <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(irq_block, 1'b0);
    sp(16'hF000, 2'h2, 16'h0001, 8'hFF);
    rd(2'h1, 16'h0000);
    @(posedge clk);
    chip_erase <= 1'b1;
    @(posedge clk);
    chip_erase <= 1'b0;
    rd(2'h1, 16'h003F);
    @(posedge clk);
    {ext_lock_we, ext_lock_data} <= 7'h6F;
    @(posedge clk);
    ext_lock_we <= 1'b0;
    rd(2'h1, 16'h002F);
    wr(2'h1, 16'h0000);
    rd(2'h1, 16'h002F);
    wr(2'h3, 16'h0000);
    rd(2'h3, 16'hF080);
    rst_seq(1'b1);
    chk(reset_vector, 16'h0000);
    rd(2'h1, 16'h003F);
    summarize;
  end
endmodule
